// *** hw/scfm_params.svh ***
`ifndef SCFM_PARAMS_SVH
`define SCFM_PARAMS_SVH

// ----------------------------------------------------------------------
// Timing figures and their cycle counts at the core clock.
// ----------------------------------------------------------------------
`define SCFM_CLK_PERIOD_PS   5000
// Earliest legal return after the chain signal goes out (least time).
`define SCFM_EARLY_NS        1000
`define SCFM_EARLY_CYC       (((`SCFM_EARLY_NS * 1000) + `SCFM_CLK_PERIOD_PS - 1) \
                              / `SCFM_CLK_PERIOD_PS)
// Wait for the return before declaring it missing (least time).
`define SCFM_TIMEOUT_US      1000
`define SCFM_TIMEOUT_CYC     (((`SCFM_TIMEOUT_US * 1000000) + `SCFM_CLK_PERIOD_PS - 1) \
                              / `SCFM_CLK_PERIOD_PS)
// Return held low this long counts as stuck (least time).
`define SCFM_STUCK_US        2000
`define SCFM_STUCK_CYC       (((`SCFM_STUCK_US * 1000000) + `SCFM_CLK_PERIOD_PS - 1) \
                              / `SCFM_CLK_PERIOD_PS)
// Settle time of the stop line after each change (least time).
`define SCFM_SETTLE_NS       10000
`define SCFM_SETTLE_CYC      (((`SCFM_SETTLE_NS * 1000) + `SCFM_CLK_PERIOD_PS - 1) \
                              / `SCFM_CLK_PERIOD_PS)

// ----------------------------------------------------------------------
// Sequence and layout figures.
// ----------------------------------------------------------------------
`define SCFM_PASSES          4
`define SCFM_TMR_W           20
`define SCFM_BOX_SHIFT       3
`define SCFM_MEM_DEPTH       8

`endif

// *** hw/scfm_pkg.sv ***
package scfm_pkg;

    // ------------------------------------------------------------------
    // Fault codes and sequencer states.
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        F_NONE, F_RD_PAR, F_SND_PAR, F_RET_LOW, F_NO_RET,
        F_COUNT, F_UNEXP, F_EARLY, F_STOP_LOCK
    } scfm_fault_e;

    typedef enum logic [2:0] {
        ST_IDLE, ST_STOP_LO, ST_STOP_HI, ST_PASS_RD, ST_PASS_RUN, ST_PASS_END
    } scfm_state_e;

    // ------------------------------------------------------------------
    // Carriers.
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       valid;
        logic       br;
        logic [7:0] data;
        logic       par;
        logic       snd_err;
        logic       motion;
    } scfm_rx_s;

    typedef struct packed {
        logic        valid;
        scfm_fault_e code;
        logic        br;
        logic        located;
        logic [5:0]  box;
        logic [3:0]  giver;
    } scfm_fault_s;

    typedef struct packed {
        scfm_state_e      st;
        logic             br;
        logic [1:0]       pass;
        logic [19:0]      tmr;
        logic [7:0]       cnt;
        logic [1:0]       ret_s1;
        logic [1:0]       ret_s2;
        logic [1:0]       ret_q;
        logic [1:0]       stop_s1;
        logic [1:0]       stop_s2;
        logic [1:0][19:0] stuck;
        logic [1:0]       pend;
        logic [1:0]       chain;
        logic [1:0]       stop_oe;
        logic             busy;
        logic             done;
        scfm_fault_s      flt;
    } scfm_state_s;

endpackage

// *** hw/scfm_count_mem.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "scfm_params.svh"

module scfm_count_mem (
    input  wire logic       core_clk,
    input  wire logic       we,
    input  wire logic [2:0] waddr,
    input  wire logic [7:0] wdata,
    input  wire logic [2:0] raddr,
    output logic      [7:0] rdata
);

    // ------------------------------------------------------------------
    // Pass counts per branch; read data is registered.
    // ------------------------------------------------------------------
    logic [7:0] mem [`SCFM_MEM_DEPTH];

    // Write and registered read share the clock; there is no reset, and the compared
    // pass-0 slot is written only when pass 0 ends in a return that is not early.
    always_ff @(posedge core_clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end

endmodule
`default_nettype wire

// *** hw/scfm_monitor.sv ***
// Summary of operation
// - Every message in both directions carries even parity, checked by the receiver.
// - A sensor message failing even parity raises a read-parity fault with branch.
// - A sensor reporting our message corrupted raises a send-parity fault with branch.
// - A return line held low continuously raises a return-stuck-low fault.
// - No return after the chain signal goes out raises a missing-return fault.
// - Tests count sensors several times; any differing count raises a count fault.
// - Motion reported during a test raises an unexpected-signal fault.
// - Chain faults carry branch, and box and sensor position when located.
// - A return sooner than expected raises an early-return fault.
// - Tests toggle the stop line; failure to toggle raises a stop-line-locked fault.
`timescale 1ns/1ps
`default_nettype none
`include "scfm_params.svh"

module scfm_monitor
    import scfm_pkg::*;
#(
    parameter logic [19:0] TIMEOUT_CYC = 20'(`SCFM_TIMEOUT_CYC),
    parameter logic [19:0] STUCK_CYC   = 20'(`SCFM_STUCK_CYC)
) (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        test_start,
    input  var  scfm_rx_s    rx,
    input  wire logic [7:0]  tx_data,
    output logic             tx_par,
    output logic [1:0]       chain_req,
    input  wire logic [1:0]  ret_pin,
    output logic [1:0]       stop_out,
    output logic [1:0]       stop_oe,
    input  wire logic [1:0]  stop_in,
    output logic             test_busy,
    output logic             test_done,
    output scfm_fault_s      fault
);

    // ------------------------------------------------------------------
    // Constants and helpers.
    // ------------------------------------------------------------------
    localparam logic [19:0] EARLY_CYC  = 20'(`SCFM_EARLY_CYC);
    localparam logic [19:0] SETTLE_CYC = 20'(`SCFM_SETTLE_CYC);
    localparam logic [1:0]  LAST_PASS  = 2'(`SCFM_PASSES - 1);

    // Builds a fault report; the position is the zero-based chain index.
    function automatic scfm_fault_s mk_fault(input scfm_fault_e code, input logic br,
                                             input logic loc, input logic [7:0] pos);
        scfm_fault_s f;
        f.valid   = 1'b1;
        f.code    = code;
        f.br      = br;
        f.located = loc;
        f.box     = loc ? 6'({1'b0, pos[7:`SCFM_BOX_SHIFT]}) + 6'h01 : 6'h00;
        f.giver   = loc ? 4'({1'b0, pos[`SCFM_BOX_SHIFT-1:0]}) + 4'h1 : 4'h0;
        return f;
    endfunction

    scfm_state_s s;
    scfm_state_s n;
    logic        mem_we;
    logic [7:0]  mem_rd;
    logic [1:0]  ret_fall;
    logic        rx_ok;
    logic        run_ret;
    logic        early_hit;

    scfm_count_mem u_mem (
        .core_clk (core_clk),
        .we       (mem_we),
        .waddr    ({s.br, s.pass}),
        .wdata    (s.cnt),
        .raddr    ({s.br, 2'b00}),
        .rdata    (mem_rd)
    );

    // ------------------------------------------------------------------
    // Outputs and decoded events.
    // ------------------------------------------------------------------
    // outgoing parity
    assign tx_par    = ^tx_data;
    assign chain_req = s.chain;
    assign stop_out  = 2'b00;
    assign stop_oe   = s.stop_oe;
    assign test_busy = s.busy;
    assign test_done = s.done;
    assign fault     = s.flt;
    // The return pulls the line low, so a falling edge marks its arrival.
    assign ret_fall  = s.ret_q & ~s.ret_s2;
    assign rx_ok     = ~^{rx.data, rx.par};
    assign run_ret   = (s.st == ST_PASS_RUN) && ret_fall[s.br];
    assign early_hit = s.tmr > (TIMEOUT_CYC - EARLY_CYC);
    assign mem_we    = run_ret && !early_hit;

    // ------------------------------------------------------------------
    // Next-state logic.
    // ------------------------------------------------------------------
    // Only one fault is reported per cycle; stuck-low reports wait in a
    // pending bit, the rest are rare enough that a collision is accepted.
    always_comb begin
        n         = s;
        n.flt     = '0;
        n.done    = 1'b0;
        n.ret_s1  = ret_pin;
        n.ret_s2  = s.ret_s1;
        n.ret_q   = s.ret_s2;
        n.stop_s1 = stop_in;
        n.stop_s2 = s.stop_s1;
        if (s.tmr != 20'h00000) begin
            n.tmr = s.tmr - 20'h00001;
        end
        if (s.pend[0]) begin
            n.flt = mk_fault(F_RET_LOW, 1'b0, 1'b0, 8'h00);
        end else if (s.pend[1]) begin
            n.flt = mk_fault(F_RET_LOW, 1'b1, 1'b0, 8'h00);
        end
        for (int b = 0; b < 2; b++) begin
            if (ret_fall[b] && !(s.st == ST_PASS_RUN && s.br == 1'(b))) begin
                n.flt = mk_fault(F_EARLY, 1'(b), 1'b0, 8'h00);
            end
        end
        case (s.st)
            ST_IDLE: begin
                if (test_start) begin
                    n.br      = 1'b0;
                    n.busy    = 1'b1;
                    n.stop_oe = 2'b01;
                    n.tmr     = SETTLE_CYC;
                    n.st      = ST_STOP_LO;
                end
            end
            ST_STOP_LO: begin
                if (s.tmr == 20'h00000) begin
                    if (s.stop_s2[s.br]) begin
                        n.flt = mk_fault(F_STOP_LOCK, s.br, 1'b0, 8'h00);
                    end
                    n.stop_oe = 2'b00;
                    n.tmr     = SETTLE_CYC;
                    n.st      = ST_STOP_HI;
                end
            end
            ST_STOP_HI: begin
                if (s.tmr == 20'h00000) begin
                    if (!s.stop_s2[s.br]) begin
                        n.flt = mk_fault(F_STOP_LOCK, s.br, 1'b0, 8'h00);
                    end
                    n.pass = 2'b00;
                    n.st   = ST_PASS_RD;
                end
            end
            ST_PASS_RD: begin
                n.cnt          = 8'h00;
                n.chain[s.br]  = 1'b1;
                n.tmr          = TIMEOUT_CYC;
                n.st           = ST_PASS_RUN;
            end
            ST_PASS_RUN: begin
                if (rx.valid && rx.br == s.br && rx_ok) begin
                    n.cnt = s.cnt + 8'h01;
                    if (rx.motion) begin
                        n.flt = mk_fault(F_UNEXP, s.br, 1'b1, s.cnt);
                    end
                end
                if (run_ret) begin
                    if (early_hit) begin
                        n.flt = mk_fault(F_EARLY, s.br, 1'b0, 8'h00);
                    end else if (s.pass != 2'b00 && s.cnt != mem_rd) begin
                        n.flt = mk_fault(F_COUNT, s.br, 1'b1,
                                         (s.cnt < mem_rd) ? s.cnt : mem_rd);
                    end
                    n.chain = 2'b00;
                    n.st    = ST_PASS_END;
                end else if (s.tmr == 20'h00000) begin
                    // missing return, located at first silent sensor
                    n.flt   = mk_fault(F_NO_RET, s.br, 1'b1, s.cnt);
                    n.chain = 2'b00;
                    n.st    = ST_PASS_END;
                end
            end
            ST_PASS_END: begin
                if (s.pass != LAST_PASS) begin
                    n.pass = s.pass + 2'b01;
                    n.st   = ST_PASS_RD;
                end else if (!s.br) begin
                    n.br      = 1'b1;
                    n.stop_oe = 2'b10;
                    n.tmr     = SETTLE_CYC;
                    n.st      = ST_STOP_LO;
                end else begin
                    n.busy = 1'b0;
                    n.done = 1'b1;
                    n.st   = ST_IDLE;
                end
            end
            default: begin
                n.st = ST_IDLE;
            end
        endcase
        if (rx.valid && !rx_ok) begin
            n.flt = mk_fault(F_RD_PAR, rx.br, 1'b0, 8'h00);
        end else if (rx.valid && rx.snd_err) begin
            n.flt = mk_fault(F_SND_PAR, rx.br, 1'b0, 8'h00);
        end
        // A pending report leaves only when it was the one sent.
        if (n.flt.code == F_RET_LOW) begin
            n.pend[n.flt.br] = 1'b0;
        end
        // stuck-low detection; a new set wins over the clear above
        for (int b = 0; b < 2; b++) begin
            if (s.ret_s2[b]) begin
                n.stuck[b] = 20'h00000;
            end else if (s.stuck[b] != STUCK_CYC) begin
                n.stuck[b] = s.stuck[b] + 20'h00001;
                if (s.stuck[b] == STUCK_CYC - 20'h00001) begin
                    n.pend[b] = 1'b1;
                end
            end
        end
    end

    // State register; return and stop lines idle high after reset.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            s         <= '0;
            s.st      <= ST_IDLE;
            s.ret_s1  <= 2'b11;
            s.ret_s2  <= 2'b11;
            s.ret_q   <= 2'b11;
            s.stop_s1 <= 2'b11;
            s.stop_s2 <= 2'b11;
        end else begin
            s <= n;
        end
    end

    // ------------------------------------------------------------------
    // Assertions.
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence seq_start;
        s.st == ST_IDLE && test_start;
    endsequence

    sequence seq_drive_low;
        s.stop_oe[0] [*8];
    endsequence

    a_par_good: assert property (rx.valid && rx_ok && !rx.snd_err
        |=> fault.code != F_RD_PAR && fault.code != F_SND_PAR)
        else $error("good parity message flagged");
    a_rd_par: assert property (rx.valid && !rx_ok
        |=> fault.valid && fault.code == F_RD_PAR && fault.br == $past(rx.br))
        else $error("read parity fault missing");
    a_snd_par: assert property (rx.valid && rx_ok && rx.snd_err
        |=> fault.code == F_SND_PAR && fault.br == $past(rx.br))
        else $error("send parity fault missing");
    a_stuck_pend: assert property (!s.ret_s2[0] && s.stuck[0] == STUCK_CYC - 20'h00001
        |=> s.pend[0] || (fault.code == F_RET_LOW && !fault.br))
        else $error("stuck low not caught");
    a_no_return: assert property (s.st == ST_PASS_RUN && s.tmr == 20'h00000
        && !run_ret && !rx.valid |=> fault.code == F_NO_RET ##1 s.st != ST_PASS_RUN)
        else $error("missing return not reported");
    a_count_diff: assert property (run_ret && !early_hit && s.pass != 2'b00
        && s.cnt != mem_rd && !rx.valid |=> fault.code == F_COUNT)
        else $error("count mismatch not reported");
    a_motion_test: assert property (s.st == ST_PASS_RUN && rx.valid && rx.br == s.br
        && rx_ok && !rx.snd_err && rx.motion && !run_ret |=> fault.code == F_UNEXP)
        else $error("motion during test not reported");
    a_locate_pos: assert property (fault.valid && fault.located
        |-> fault.box != 6'h00 && fault.giver != 4'h0 && fault.giver <= 4'h8)
        else $error("located fault without position");
    a_early_ret: assert property (run_ret && early_hit && !rx.valid
        |=> fault.code == F_EARLY && s.st == ST_PASS_END)
        else $error("early return not reported");
    a_stop_seq: assert property (seq_start |=> seq_drive_low)
        else $error("stop line not driven low at test start");
    a_chain_pos: assert property (s.st == ST_PASS_RD ##1 rx.valid && rx.br == s.br
        && rx_ok && !rx.snd_err && rx.motion && !run_ret |=> fault.giver == 4'h1)
        else $error("first sensor not at position one");

endmodule
`default_nettype wire

// *** testbench/scfm_chain_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module scfm_chain_model
    import scfm_pkg::*;
(
    input  wire logic [1:0] chain_req,
    input  wire logic       core_clk,
    input  wire logic [1:0] stop_oe,
    input  wire logic [1:0] hold_low,
    input  wire logic [1:0] lock,
    output var  scfm_rx_s   rx,
    output logic      [1:0] ret_pin,
    output logic      [1:0] stop_in
);
    // Per-branch setup, written by the bench before each test.
    int         n_sens    [2] = '{10, 10};
    int         short_pass[2] = '{4, 4};
    int         mot_pos   [2] = '{-1, -1};
    int         ret_dly   [2] = '{250, 250};
    logic [1:0] ret_q         = 2'h3;

    // ------------------------------------------------------------------
    // Pins and messages.
    // ------------------------------------------------------------------
    // Pull-ups on both lines; a locked stop line is held low by a bad sensor.
    assign ret_pin = ret_q & ~hold_low;
    assign stop_in = ~stop_oe & ~lock;

    initial rx = '0;

    // even parity
    // An idle message bus shows inverted junk, never the last value.
    task automatic send(input logic br, input logic [7:0] d, input logic p,
                        input logic se, input logic mo);
        @(negedge core_clk);
        rx <= '{1'b1, br, d, p, se, mo};
        @(negedge core_clk);
        rx <= '{1'b0, ~br, ~d, ~p, ~se, ~mo};
    endtask

    // One sensor chain per branch; a pass answers each chain signal.
    for (genvar b = 0; b < 2; b++) begin : g_br
        int pass = 0;
        initial begin
            forever begin
                @(posedge chain_req[b]);
                for (int i = 0; i < n_sens[b] - int'(pass == short_pass[b]); i++) begin
                    send(1'(b), 8'(i), ^8'(i), 1'b0, pass == 0 && i == mot_pos[b]);
                    repeat (2) @(negedge core_clk);
                end
                if (ret_dly[b] >= 0) begin
                    repeat (ret_dly[b]) @(negedge core_clk);
                    ret_q[b] = 1'b0;
                end
                @(negedge chain_req[b]);
                @(negedge core_clk);
                ret_q[b] = 1'b1;
                pass = (pass + 1) % 4;
            end
        end
    end
endmodule

`default_nettype wire

// *** testbench/tb.sv ***
`timescale 1ns/1ps
`default_nettype none

module tb;
    import scfm_pkg::*;

    logic        core_clk   = 1'b0;
    logic        rst        = 1'b1;
    logic        test_start = 1'b0;
    logic [7:0]  tx_data    = 8'h00;
    logic [1:0]  hold_low   = 2'h0;
    logic [1:0]  lock       = 2'h0;
    logic        tx_par;
    logic [1:0]  chain_req;
    logic [1:0]  ret_pin;
    logic [1:0]  stop_oe;
    logic [1:0]  stop_out;
    logic [1:0]  stop_in;
    logic        test_busy;
    logic        test_done;
    logic [1:0]  req_q      = 2'h0;
    scfm_rx_s    rx;
    scfm_fault_s fault;
    scfm_fault_s flog[$];
    int          failures   = 0;
    int          checks     = 0;
    int          rises      = 0;

    // ------------------------------------------------------------------
    // Clock, design and sensor chain.
    // ------------------------------------------------------------------
    always #2.5 core_clk = ~core_clk;

    // Short counts keep the run brief; expectations follow these values.
    scfm_monitor #(.TIMEOUT_CYC(20'h007D0), .STUCK_CYC(20'h001F4)) i_scfm_monitor (
        .core_clk(core_clk), .rst(rst), .test_start(test_start), .rx(rx),
        .tx_data(tx_data), .tx_par(tx_par), .chain_req(chain_req),
        .ret_pin(ret_pin), .stop_out(stop_out), .stop_oe(stop_oe), .stop_in(stop_in),
        .test_busy(test_busy), .test_done(test_done), .fault(fault)
    );

    scfm_chain_model i_model (
        .chain_req(chain_req), .core_clk(core_clk), .stop_oe(stop_oe),
        .hold_low(hold_low), .lock(lock), .rx(rx), .ret_pin(ret_pin),
        .stop_in(stop_in)
    );

    // Log every fault report and count chain signals sent.
    always @(posedge core_clk) begin
        if (fault.valid === 1'b1) begin
            flog.push_back(fault);
        end
        rises <= rises + $countones(chain_req & ~req_q);
        req_q <= chain_req;
    end

    // ------------------------------------------------------------------
    // Helpers.
    // ------------------------------------------------------------------
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    function automatic int n_code(input scfm_fault_e code, input logic br);
        n_code = 0;
        foreach (flog[i]) begin
            if (flog[i].code == code && flog[i].br == br) n_code++;
        end
    endfunction

    // Position -1 means unlocated, -2 means the location is not judged.
    task automatic expect_fault(input scfm_fault_e code, input logic br, input int pos);
        scfm_fault_s f;
        f = '0;
        foreach (flog[i]) begin
            if (flog[i].code == code && flog[i].br == br) f = flog[i];
        end
        chk("fault code", 16'(code), 16'(f.code));
        chk("fault branch", 16'(br), 16'(f.br));
        if (pos > -2) begin
            chk("fault located", 16'(pos >= 0), 16'(f.located));
            chk("fault box", pos >= 0 ? 16'(pos / 8 + 1) : 16'h0000, 16'(f.box));
            chk("fault giver", pos >= 0 ? 16'(pos % 8 + 1) : 16'h0000, 16'(f.giver));
        end
    endtask

    task automatic setup(input int n0, input int sp0, input int m0, input int m1,
                         input int d0, input int d1);
        i_model.n_sens  = '{n0, 10};
        i_model.short_pass = '{sp0, 4};
        i_model.mot_pos = '{m0, m1};
        i_model.ret_dly = '{d0, d1};
    endtask

    // Starts a test and waits a bounded time for its end pulse.
    task automatic run_test(input string name);
        int n;
        flog.delete();
        rises = 0;
        @(negedge core_clk);
        test_start = 1'b1;
        @(negedge core_clk);
        test_start = 1'b0;
        chk("busy", 16'h0001, 16'(test_busy));
        chk("stop out", 16'h0000, 16'(stop_out));
        n = 0;
        while (test_done !== 1'b1 && n < 30000) begin
            @(negedge core_clk);
            n++;
        end
        chk("done", 16'h0001, 16'(test_done));
        chk("busy at done", 16'h0000, 16'(test_busy));
        @(negedge core_clk);
        $display("Test %s ended", name);
    endtask

    // ------------------------------------------------------------------
    // Scenarios.
    // ------------------------------------------------------------------
    task automatic t_parity;
        // The step gives bytes of both parities, so a stuck bit is caught.
        for (int v = 0; v < 256; v += 37) begin
            @(negedge core_clk);
            tx_data = 8'(v);
            #1;
            chk("tx parity", 16'($countones(tx_data) % 2), 16'(tx_par));
        end
        i_model.send(1'b1, 8'h5A, 1'b1, 1'b0, 1'b0);
        chk("read parity code", 16'(F_RD_PAR), 16'(fault.code));
        chk("read parity branch", 16'h0001, 16'(fault.br));
        chk("read parity located", 16'h0000, 16'(fault.located));
        @(negedge core_clk);
        chk("fault one cycle", 16'h0000, 16'(fault.valid));
        i_model.send(1'b0, 8'h5A, 1'b0, 1'b1, 1'b0);
        chk("send parity code", 16'(F_SND_PAR), 16'(fault.code));
        chk("send parity branch", 16'h0000, 16'(fault.br));
        $display("Test parity ended");
    endtask

    task automatic t_stuck;
        flog.delete();
        @(negedge core_clk);
        hold_low = 2'h3;
        repeat (480) @(negedge core_clk);
        chk("stuck too soon", 16'h0000, 16'(n_code(F_RET_LOW, 1'b1)));
        repeat (40) @(negedge core_clk);
        expect_fault(F_EARLY, 1'b1, -1);
        expect_fault(F_RET_LOW, 1'b1, -1);
        expect_fault(F_RET_LOW, 1'b0, -1);
        chk("stuck once", 16'h0001, 16'(n_code(F_RET_LOW, 1'b1)));
        hold_low = 2'h0;
        repeat (10) @(negedge core_clk);
        $display("Test stuck ended");
    endtask

    task automatic t_good;
        setup(10, 4, -1, -1, 250, 250);
        run_test("good chain");
        chk("fault count", 16'h0000, 16'(flog.size()));
        chk("chain passes", 16'h0008, 16'(rises));
    endtask

    task automatic t_count_motion;
        setup(10, 1, 0, 3, 250, 250);
        run_test("count and motion");
        expect_fault(F_COUNT, 1'b0, 9);
        expect_fault(F_UNEXP, 1'b0, 0);
        expect_fault(F_UNEXP, 1'b1, 3);
    endtask

    task automatic t_lock;
        setup(10, 4, -1, -1, 250, 250);
        lock = 2'h1;
        run_test("stop lock");
        lock = 2'h0;
        expect_fault(F_STOP_LOCK, 1'b0, -2);
        chk("branch 1 no lock", 16'h0000, 16'(n_code(F_STOP_LOCK, 1'b1)));
    endtask

    task automatic t_return;
        setup(10, 4, -1, -1, 0, -1);
        run_test("return faults");
        expect_fault(F_EARLY, 1'b0, -2);
        expect_fault(F_NO_RET, 1'b1, 10);
    endtask

    // ------------------------------------------------------------------
    // Run control.
    // ------------------------------------------------------------------
    task automatic finish_test;
        $display("Checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // The tests need about 50000 cycles; 90000 means a hang.
    initial begin
        #450000;
        failures++;
        $display("CHECK FAILED watchdog expected end seen timeout");
        finish_test();
    end

    initial begin
        repeat (5) @(negedge core_clk);
        rst = 1'b0;
        chk("idle chain", 16'h0000, 16'(chain_req));
        chk("idle fault", 16'h0000, 16'(fault.valid));
        t_parity();
        t_stuck();
        t_good();
        t_count_motion();
        t_lock();
        t_return();
        finish_test();
    end
endmodule

`default_nettype wire
